// ==== timer_capture_pkg.sv ====
//------------------------------------------------------------------------
// register map, field layout and reset values of the capture timer
//------------------------------------------------------------------------
// Behaviour
// (R01) two channels latch the whole 16-bit counter on a pin transition
// (R02) capture registers are read-only, split into high and low bytes
// (R03) each channel has its own rising/falling edge select bit
// (R04) counter ticks at pclk divided by a two-bit clock select field
// (R05) one capture interrupt enable covers both capture channels
// (R06) a capture sets the channel flag and loads the counter value
// (R07) interrupt asserts only when enabled and global mask clear
// (R08) flag clears after status read while set, then low-byte access
// (R09) high-byte read blocks captures and flag until low byte read
// (R10) capture register always holds the most recent capture value
// (R11) captures keep working while output compares are in use
// (R12) in one-pulse or pwm mode only channel 2 captures
// (R13) pins always feed capture logic; any selected edge triggers it
// (R14) software may read high byte to hold off unwanted captures
// (R15) software configures capture pins as floating or pull-up inputs
// (R16) overflow flag and its interrupt extend measurable intervals
// (R17) counter high byte shows the upper half of the counter
// (R18) counter low byte shows the lower half of the counter
// (R19) any write to counter low byte resets the counter
// (R20) overflow flag clears on low-byte access after status access; the code arms the clear only on a status read while set
// (R21) compare 2 low byte holds low half of the compare value
// (R22) counter increments per tick, wraps to zero, sets overflow
// (R23) pins are synchronised and edges found from successive samples
package timer_capture_pkg;

    //--------------------------------------------------------------------
    // bus geometry
    //--------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 16;
    localparam int NCHAN  = 2;

    //--------------------------------------------------------------------
    // byte offsets, one aligned word each
    //--------------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL_ONE  = 8'h00;
    localparam logic [7:0] OFF_CTRL_TWO  = 8'h04;
    localparam logic [7:0] OFF_STATUS    = 8'h08;
    localparam logic [7:0] OFF_CAP1_HIGH = 8'h0C;
    localparam logic [7:0] OFF_CAP1_LOW  = 8'h10;
    localparam logic [7:0] OFF_CAP2_HIGH = 8'h14;
    localparam logic [7:0] OFF_CAP2_LOW  = 8'h18;
    localparam logic [7:0] OFF_CNT_HIGH  = 8'h1C;
    localparam logic [7:0] OFF_CNT_LOW   = 8'h20;
    localparam logic [7:0] OFF_CMP2_LOW  = 8'h24;

    //--------------------------------------------------------------------
    // field positions
    //--------------------------------------------------------------------
    localparam int CTRL1_CAP_IRQ_EN  = 7;
    localparam int CTRL1_OVF_IRQ_EN  = 5;
    localparam int CTRL1_EDGE_SEL    = 1;
    localparam int CTRL2_PWM_MODE    = 5;
    localparam int CTRL2_ONE_PULSE   = 4;
    localparam int CTRL2_CLK_SEL_HI  = 3;
    localparam int CTRL2_CLK_SEL_LO  = 2;
    localparam int CTRL2_EDGE_SEL    = 1;
    localparam int STAT_CAP_FLAG1    = 7;
    localparam int STAT_OVF_FLAG     = 5;
    localparam int STAT_CAP_FLAG2    = 4;

    //--------------------------------------------------------------------
    // reset values and prescaler divisors
    //--------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_COUNTER = 16'h0000;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [2:0]  DIV_SEL0    = 3'h3;   // divide by 4
    localparam logic [2:0]  DIV_SEL1    = 3'h1;   // divide by 2
    localparam logic [2:0]  DIV_SEL2    = 3'h7;   // divide by 8
    localparam logic [1:0]  CLK_STOP    = 2'h3;   // counter halted

endpackage : timer_capture_pkg

// ==== timer_input_capture.sv ====
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
module timer_input_capture (
    // clock and reset
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    // apb slave
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [timer_capture_pkg::ADDR_W-1:0] paddr,
    input  wire logic [timer_capture_pkg::DATA_W-1:0] pwdata,
    output logic                                    pready,
    output logic      [timer_capture_pkg::DATA_W-1:0] prdata,
    output logic                                    pslverr,
    // capture pins, asynchronous to pclk
    input  wire logic [timer_capture_pkg::NCHAN-1:0]  capture_input_pin,
    // cpu global interrupt mask, high masks
    input  wire logic                               cpu_irq_mask,
    // interrupt and compare value to shared compare logic
    output logic                                    timer_irq,
    output logic      [7:0]                         compare2_low_byte
);
    import timer_capture_pkg::*;

    //--------------------------------------------------------------------
    // address decode helper
    //--------------------------------------------------------------------
    function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                    input logic [7:0]        off);
        is_reg = (a[7:2] == off[7:2]);
    endfunction : is_reg

    //--------------------------------------------------------------------
    // state
    //--------------------------------------------------------------------
    logic [7:0]        ctrl_one_ff;
    logic [7:0]        ctrl_two_ff;
    logic [7:0]        cmp2_low_ff;
    logic [CNT_W-1:0]  counter_ff;
    logic [2:0]        psc_ff;
    logic              ovf_flag_ff;
    logic              ovf_arm_ff;
    logic [NCHAN-1:0]  sync1_ff;
    logic [NCHAN-1:0]  sync2_ff;
    logic [NCHAN-1:0]  prev_ff;
    logic [NCHAN-1:0]  cap_flag_ff;
    logic [NCHAN-1:0]  cap_arm_ff;
    logic [NCHAN-1:0]  inhibit_ff;
    logic [CNT_W-1:0]  cap_value_ff [NCHAN];
    logic              pready_ff;
    logic              pslverr_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic              irq_ff;

    //--------------------------------------------------------------------
    // bus phase decode
    //--------------------------------------------------------------------
    logic       setup;
    logic       acc;
    logic       wr_acc;
    logic       rd_acc;
    logic       hit_ctrl_one;
    logic       hit_ctrl_two;
    logic       hit_status;
    logic       hit_cnt_high;
    logic       hit_cnt_low;
    logic       hit_cmp2_low;
    logic [NCHAN-1:0] hit_cap_high;
    logic [NCHAN-1:0] hit_cap_low;
    logic       mapped;

    // no wait state: read data is latched at setup, effects at access
    assign setup  = psel & ~penable;
    assign acc    = psel & penable & pready_ff;
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;

    assign hit_ctrl_one    = is_reg(paddr, OFF_CTRL_ONE);
    assign hit_ctrl_two    = is_reg(paddr, OFF_CTRL_TWO);
    assign hit_status      = is_reg(paddr, OFF_STATUS);
    assign hit_cap_high[0] = is_reg(paddr, OFF_CAP1_HIGH);
    assign hit_cap_low[0]  = is_reg(paddr, OFF_CAP1_LOW);
    assign hit_cap_high[1] = is_reg(paddr, OFF_CAP2_HIGH);
    assign hit_cap_low[1]  = is_reg(paddr, OFF_CAP2_LOW);
    assign hit_cnt_high    = is_reg(paddr, OFF_CNT_HIGH);
    assign hit_cnt_low     = is_reg(paddr, OFF_CNT_LOW);
    assign hit_cmp2_low    = is_reg(paddr, OFF_CMP2_LOW);
    assign mapped = hit_ctrl_one | hit_ctrl_two | hit_status |
                    (|hit_cap_high) | (|hit_cap_low) | hit_cnt_high |
                    hit_cnt_low | hit_cmp2_low;

    //--------------------------------------------------------------------
    // access side effects
    //--------------------------------------------------------------------
    logic       status_rd;
    logic       cnt_low_acc;
    logic       cnt_low_wr;
    logic [NCHAN-1:0] cap_low_acc;
    logic [NCHAN-1:0] cap_low_rd;
    logic [NCHAN-1:0] cap_high_rd;

    assign status_rd   = rd_acc & hit_status;
    assign cnt_low_acc = acc & hit_cnt_low;
    assign cnt_low_wr  = wr_acc & hit_cnt_low;
    assign cap_low_acc = {NCHAN{acc}} & hit_cap_low;
    assign cap_low_rd  = {NCHAN{rd_acc}} & hit_cap_low;
    assign cap_high_rd = {NCHAN{rd_acc}} & hit_cap_high;

    //--------------------------------------------------------------------
    // control registers
    //--------------------------------------------------------------------
    // all bits stored; unused ones are only read back, no compare or pwm logic uses them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_one_ff <= RST_BYTE;
            ctrl_two_ff <= RST_BYTE;
            cmp2_low_ff <= RST_BYTE;
        end else if (wr_acc) begin
            if (hit_ctrl_one) ctrl_one_ff <= pwdata[7:0];
            if (hit_ctrl_two) ctrl_two_ff <= pwdata[7:0];
            if (hit_cmp2_low) cmp2_low_ff <= pwdata[7:0]; // see (R21)
        end
    end

    //--------------------------------------------------------------------
    // prescaler
    //--------------------------------------------------------------------
    logic [1:0] clk_sel;
    logic [2:0] div_last;
    logic       tick;
    logic [2:0] nxt_psc;

    assign clk_sel  = ctrl_two_ff[CTRL2_CLK_SEL_HI:CTRL2_CLK_SEL_LO];
    // select 3 halts the counter: no external clock source here
    assign div_last = (clk_sel == 2'h0) ? DIV_SEL0 :
                      (clk_sel == 2'h1) ? DIV_SEL1 : DIV_SEL2;
    assign tick     = (clk_sel != CLK_STOP) &&
                      (psc_ff >= div_last);             // see (R04)
    assign nxt_psc  = (tick || clk_sel == CLK_STOP) ? 3'h0 :
                      3'(psc_ff + 3'h1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) psc_ff <= 3'h0;
        else          psc_ff <= nxt_psc;
    end

    //--------------------------------------------------------------------
    // free-running counter and overflow flag
    //--------------------------------------------------------------------
    logic             wrap;
    logic [CNT_W-1:0] nxt_counter;
    logic             nxt_ovf_flag;
    logic             nxt_ovf_arm;

    // a write to the low byte wins over a tick in the same cycle
    assign wrap        = tick & (counter_ff == CNT_MAX) & ~cnt_low_wr;
    assign nxt_counter = cnt_low_wr ? RST_COUNTER :            // see (R19)
                         tick ? CNT_W'(counter_ff + 16'h0001) :  // see (R22)
                         counter_ff;
    // status read arms the clear; a wrap in the clear cycle still sets
    assign nxt_ovf_flag = wrap |                                // see (R22)
                          (ovf_flag_ff & ~(ovf_arm_ff & cnt_low_acc));
    assign nxt_ovf_arm  = (ovf_arm_ff | (status_rd & ovf_flag_ff)) &
                          ~cnt_low_acc;                         // see (R20)

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            counter_ff  <= RST_COUNTER;
            ovf_flag_ff <= 1'b0;
            ovf_arm_ff  <= 1'b0;
        end else begin
            counter_ff  <= nxt_counter;
            ovf_flag_ff <= nxt_ovf_flag;                        // see (R16)
            ovf_arm_ff  <= nxt_ovf_arm;
        end
    end

    //--------------------------------------------------------------------
    // capture channels
    //--------------------------------------------------------------------
    logic [NCHAN-1:0] edge_sel;
    logic [NCHAN-1:0] chan_ok;
    logic [NCHAN-1:0] rise;
    logic [NCHAN-1:0] fall;
    logic [NCHAN-1:0] cap_evt;
    logic [NCHAN-1:0] nxt_cap_flag;
    logic [NCHAN-1:0] nxt_cap_arm;
    logic [NCHAN-1:0] nxt_inhibit;
    logic             pulse_mode;

    assign edge_sel   = {ctrl_two_ff[CTRL2_EDGE_SEL],
                         ctrl_one_ff[CTRL1_EDGE_SEL]};          // see (R03)
    assign pulse_mode = ctrl_two_ff[CTRL2_PWM_MODE] |
                        ctrl_two_ff[CTRL2_ONE_PULSE];
    // channel 1 is taken over by the pulse generator in those modes
    assign chan_ok    = {1'b1, ~pulse_mode};                    // see (R12)

    // edge found from second sync stage against its previous sample
    assign rise = sync2_ff & ~prev_ff;                          // see (R23)
    assign fall = ~sync2_ff & prev_ff;
    // pins are never gated by port direction, the selected edge counts
    assign cap_evt = ((edge_sel & rise) | (~edge_sel & fall)) &
                     chan_ok & ~inhibit_ff;                     // see (R13)
    // new capture beats a simultaneous clear
    assign nxt_cap_flag = cap_evt |
                          (cap_flag_ff & ~(cap_arm_ff & cap_low_acc));
    assign nxt_cap_arm  = (cap_arm_ff |
                          ({NCHAN{status_rd}} & cap_flag_ff)) &
                          ~cap_low_acc;                         // see (R08)
    assign nxt_inhibit  = (inhibit_ff | cap_high_rd) &
                          ~cap_low_rd;                          // see (R09)

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff    <= '0;
            sync2_ff    <= '0;
            prev_ff     <= '0;
            cap_flag_ff <= '0;
            cap_arm_ff  <= '0;
            inhibit_ff  <= '0;
        end else begin
            sync1_ff    <= capture_input_pin;
            sync2_ff    <= sync1_ff;
            prev_ff     <= sync2_ff;
            cap_flag_ff <= nxt_cap_flag;                        // see (R06)
            cap_arm_ff  <= nxt_cap_arm;
            inhibit_ff  <= nxt_inhibit;
        end
    end

    // each channel overwrites on every capture, compares run alongside
    genvar gi;
    generate
        for (gi = 0; gi < NCHAN; gi++) begin : g_cap
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn)
                    cap_value_ff[gi] <= RST_COUNTER;
                else if (cap_evt[gi])
                    cap_value_ff[gi] <= counter_ff;  // see (R01) (R10) (R11)
            end
        end
    endgenerate

    //--------------------------------------------------------------------
    // interrupt
    //--------------------------------------------------------------------
    logic irq_src;
    logic nxt_irq;

    // flags stay set while masked, so the request waits as pending
    assign irq_src = (ctrl_one_ff[CTRL1_CAP_IRQ_EN] & (|cap_flag_ff)) |
                     (ctrl_one_ff[CTRL1_OVF_IRQ_EN] & ovf_flag_ff);
    assign nxt_irq = irq_src & ~cpu_irq_mask;            // see (R05) (R07)

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_ff <= 1'b0;
        else          irq_ff <= nxt_irq;
    end

    //--------------------------------------------------------------------
    // read mux
    //--------------------------------------------------------------------
    logic [7:0]        status_byte;
    logic [7:0]        rd_byte;
    logic [DATA_W-1:0] nxt_prdata;

    always_comb begin
        status_byte                 = RST_BYTE;
        status_byte[STAT_CAP_FLAG1] = cap_flag_ff[0];
        status_byte[STAT_OVF_FLAG]  = ovf_flag_ff;
        status_byte[STAT_CAP_FLAG2] = cap_flag_ff[1];
    end

    // capture bytes only readable, never written; see (R02)
    assign rd_byte =
        hit_ctrl_one    ? ctrl_one_ff :
        hit_ctrl_two    ? ctrl_two_ff :
        hit_status      ? status_byte :
        hit_cap_high[0] ? cap_value_ff[0][15:8] :
        hit_cap_low[0]  ? cap_value_ff[0][7:0] :
        hit_cap_high[1] ? cap_value_ff[1][15:8] :
        hit_cap_low[1]  ? cap_value_ff[1][7:0] :
        hit_cnt_high    ? counter_ff[15:8] :                    // see (R17)
        hit_cnt_low     ? counter_ff[7:0] :                     // see (R18)
        hit_cmp2_low    ? cmp2_low_ff : RST_BYTE;
    assign nxt_prdata = {24'h000000, rd_byte};

    //--------------------------------------------------------------------
    // apb response
    //--------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
        end else if (setup) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= ~mapped;
            prdata_ff  <= pwrite ? '0 : nxt_prdata;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // outputs
    //--------------------------------------------------------------------
    assign pready            = pready_ff;
    assign pslverr           = pslverr_ff;
    assign prdata            = prdata_ff;
    assign timer_irq         = irq_ff;
    assign compare2_low_byte = cmp2_low_ff;

endmodule : timer_input_capture

// ==== capture_source.sv ====
`timescale 1ns/10ps
//----------------------------------------------------------------
// signal source on the two capture pins
//----------------------------------------------------------------
module capture_source (
    // levels requested by the bench
    input  wire logic [1:0] level_req,
    // pins seen by the timer
    output logic      [1:0] pins
);
    // push-pull drive, never floating; lags so edges avoid pclk edges
    initial pins = 2'h0;
    always @(level_req) pins <= #7 level_req;
endmodule : capture_source

// ==== timer_input_capture_checker.sv ====
`timescale 1ns/10ps
module timer_input_capture_checker
    import timer_capture_pkg::*;
(
    // clock and reset
    input wire logic                                   pclk,
    input wire logic                                   presetn,
    // apb
    input wire logic                                   psel,
    input wire logic                                   penable,
    input wire logic                                   pwrite,
    input wire logic [timer_capture_pkg::ADDR_W-1:0]   paddr,
    input wire logic [timer_capture_pkg::DATA_W-1:0]   pwdata,
    input wire logic                                   pready,
    input wire logic [timer_capture_pkg::DATA_W-1:0]   prdata,
    input wire logic                                   pslverr,
    // pins and interrupt
    input wire logic [timer_capture_pkg::NCHAN-1:0]    capture_input_pin,
    input wire logic                                   cpu_irq_mask,
    input wire logic                                   timer_irq,
    input wire logic [7:0]                             compare2_low_byte
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // completed write to the compare byte
    wire cmp_wr = psel && penable && pready && pwrite
                  && paddr[7:2] == OFF_CMP2_LOW[7:2];

    ready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready one cycle after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready stood longer than one cycle");
    err_decode_a: assert property (
        pready |-> pslverr == (paddr[7:2] > OFF_CMP2_LOW[7:2]))
        else $error("slave error does not match address decode");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data not zero on write");
    irq_masked_a: assert property (
        cpu_irq_mask ##1 cpu_irq_mask |-> !timer_irq)
        else $error("interrupt raised while cpu mask set");
    cmp2_load_a: assert property (cmp_wr |=>
        {24'h0, compare2_low_byte} == ($past(pwdata) & 32'h0000_00FF))
        else $error("compare byte did not take written value");
    cmp2_hold_a: assert property (
        !cmp_wr |=> $stable(compare2_low_byte))
        else $error("compare byte changed without a write");
endmodule : timer_input_capture_checker

bind timer_input_capture timer_input_capture_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr),
    .capture_input_pin(capture_input_pin), .cpu_irq_mask(cpu_irq_mask),
    .timer_irq(timer_irq), .compare2_low_byte(compare2_low_byte));

// ==== tb_timer_input_capture.sv ====
`timescale 1ns/10ps
module tb_timer_input_capture;
    import timer_capture_pkg::*;
    logic              pclk, presetn, psel, penable, pwrite, cpu_irq_mask;
    logic              pready, pslverr, timer_irq;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata;
    logic [7:0]        compare2_low_byte;
    logic [1:0]        pin_req, capture_input_pin;
    logic [31:0]       exp_q[$], msk_q[$], v, junk, lfsr;
    logic [15:0]       c;
    int                err_count, checks_done;

    //------------------------------------------------------------
    // clock, partner and design
    //------------------------------------------------------------
    initial pclk = 1'b0;
    always #12.5 pclk = ~pclk;

    capture_source src (.level_req(pin_req), .pins(capture_input_pin));

    timer_input_capture dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr),
        .capture_input_pin(capture_input_pin),
        .cpu_irq_mask(cpu_irq_mask), .timer_irq(timer_irq),
        .compare2_low_byte(compare2_low_byte));

    //------------------------------------------------------------
    // helpers
    //------------------------------------------------------------
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    // one apb transfer; released a full cycle before the next setup
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, input logic [31:0] e,
                        input logic [31:0] m, output logic [31:0] r);
        if (!wr) begin
            exp_q.push_back(e);
            msk_q.push_back(m);
        end
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'h0000_00FF);
        xfer(1'b0, a, 32'h0, e, m, v);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 32'h0, junk);
    endtask : wr

    task automatic pin(input int ch, input logic lv);
        pin_req[ch] <= lv;
        idle(8);
    endtask : pin

    // run the counter a random span, stop it and note where it stood
    task automatic freeze();
        lfsr = nxt(lfsr);
        wr(OFF_CTRL_TWO, 32'h04);
        idle(40 + int'(lfsr[4:0]));
        wr(OFF_CTRL_TWO, 32'h0C);
        rd(OFF_CNT_HIGH, 32'h0, 32'h0);
        c[15:8] = v[7:0];
        rd(OFF_CNT_LOW, 32'h0, 32'h0);
        c[7:0] = v[7:0];
    endtask : freeze

    // every completed read is compared against the oldest note
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1 && !pwrite)
            check(prdata & msk_q.pop_front(), exp_q.pop_front());

    initial begin
        #2000000;
        err_count++;
        finish_test();
    end

    //------------------------------------------------------------
    // main sequence
    //------------------------------------------------------------
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; pin_req = 2'h0;
        cpu_irq_mask = 1'b1; lfsr = 32'h0001_790F;
        err_count = 0; checks_done = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL_ONE, 32'h0);
        rd(OFF_STATUS, 32'h0);
        rd(8'h40, 32'h0, 32'hFFFF_FFFF);
        lfsr = nxt(lfsr);
        wr(OFF_CMP2_LOW, lfsr);
        rd(OFF_CMP2_LOW, {24'h0, lfsr[7:0]}, 32'hFFFF_FFFF);
        // reads spaced 3+k cycles apart must differ by (3+k)/divisor
        for (int i = 0; i < 3; i++) begin
            automatic int dv = (i == 0) ? 4 : (i == 1) ? 2 : 8;
            automatic int k  = (dv == 8) ? 5 : 1;
            wr(OFF_CTRL_TWO, i << 2);
            rd(OFF_CNT_LOW, 32'h0, 32'h0);
            c[7:0] = v[7:0];
            idle(k);
            c[7:0] = c[7:0] + 8'((3 + k) / dv);
            rd(OFF_CNT_LOW, c[7:0]);
        end
        lfsr = nxt(lfsr);
        wr(OFF_CTRL_TWO, 32'h0C);
        wr(OFF_CNT_LOW, lfsr);
        rd(OFF_CNT_HIGH, 32'h0);
        rd(OFF_CNT_LOW, 32'h0);
        freeze();
        wr(OFF_CTRL_ONE, 32'h82);
        pin(0, 1'b1);
        check(timer_irq, 1'b0);
        rd(OFF_STATUS, 32'h80);
        cpu_irq_mask <= 1'b0;
        idle(2);
        check(timer_irq, 1'b1);
        rd(OFF_CAP1_HIGH, c[15:8]);
        rd(OFF_CAP1_LOW, c[7:0]);
        idle(1);
        check(timer_irq, 1'b0);
        rd(OFF_STATUS, 32'h0);
        // high byte read holds off the next capture
        rd(OFF_CAP1_HIGH, c[15:8]);
        pin(0, 1'b0);
        pin(0, 1'b1);
        rd(OFF_STATUS, 32'h0);
        rd(OFF_CAP1_LOW, c[7:0]);
        freeze();
        pin(0, 1'b0);
        rd(OFF_STATUS, 32'h0);
        pin(0, 1'b1);
        rd(OFF_STATUS, 32'h80);
        rd(OFF_CAP1_HIGH, c[15:8]);
        rd(OFF_CAP1_LOW, c[7:0]);
        // channel 2 captures on the falling edge; writes are ignored
        pin(1, 1'b1);
        check(timer_irq, 1'b0);
        rd(OFF_STATUS, 32'h0);
        pin(1, 1'b0);
        check(timer_irq, 1'b1);
        rd(OFF_STATUS, 32'h10);
        wr(OFF_CAP2_HIGH, 32'hFF);
        rd(OFF_CAP2_HIGH, c[15:8]);
        rd(OFF_CAP2_LOW, c[7:0]);
        // one-pulse then pwm: channel 1 goes deaf, channel 2 works
        for (int i = 0; i < 2; i++) begin
            wr(OFF_CTRL_TWO, (i == 0) ? 32'h1C : 32'h2C);
            pin(0, 1'b0);
            pin(0, 1'b1);
            pin(1, 1'b1);
            pin(1, 1'b0);
            rd(OFF_STATUS, 32'h10);
            rd(OFF_CAP2_LOW, c[7:0]);
        end
        finish_test();
    end
endmodule : tb_timer_input_capture
